// file: mu_defines.vh
// constants for the node serial port, 9600 baud packet handshake mode
`ifndef MU_DEFINES_VH
`define MU_DEFINES_VH
`define MU_CLK_HZ 200000000
`define MU_BAUD 9600
// core clock cycles per bit: clock rate over baud rate, sized for the bit counters
`define MU_BIT_CYCLES 16'd20833
`define MU_DATA_BITS 8
`define MU_RTS_TIMEOUT_CYC 32'd2000000
`define MU_RTS_RETRY_CYC 32'd200000
`define MU_TIME_PKT_BYTE 8'h54
`endif

// file: mu_uart_tx.v
// serial byte transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`default_nettype none
`include "mu_defines.vh"
module mu_uart_tx #(
	parameter [15:0] BIT_CYC = `MU_BIT_CYCLES
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire start_i,
	input wire [7:0] data_i,
	output reg busy_o,
	output reg txd_o
);
	reg [15:0] cnt_ff;
	reg [3:0] bit_ff;
	reg [9:0] shf_ff;
	// -------------------------------------------------------------------
	// frame shifter: start bit, data lsb first, stop bit
	// -------------------------------------------------------------------
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			txd_o <= 1'b1;
			cnt_ff <= 16'h0000;
			bit_ff <= 4'h0;
			shf_ff <= 10'h3ff;
		end else if (!busy_o) begin
			txd_o <= 1'b1;
			if (start_i) begin
				busy_o <= 1'b1;
				shf_ff <= {1'b1, data_i, 1'b0};
				cnt_ff <= 16'h0000;
				bit_ff <= 4'h0;
			end
		end else begin
			txd_o <= shf_ff[0];
			if (cnt_ff == BIT_CYC - 16'h0001) begin
				cnt_ff <= 16'h0000;
				shf_ff <= {1'b1, shf_ff[9:1]};
				bit_ff <= bit_ff + 4'h1;
				if (bit_ff == 4'h9)
					busy_o <= 1'b0;
			end else begin
				cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// file: mu_uart_node.v
// node serial port: receiver, transmitter and packet handshake lines
`timescale 1ns/1ps
`default_nettype none
`include "mu_defines.vh"
// Behaviour
// - host data enters only on the receive line.
// - all node data leaves on the transmit line.
// - request-to-send asserts when a packet is pending.
// - request-to-send stays low until host clear-to-send low or timeout.
// - on timeout deassert, wait retry delay, reassert for same packet.
// - node clear-to-send high after reset until network joined.
// - node clear-to-send high when no room for another packet.
// - node clear-to-send high while not a network member.
// - local command packets accepted whatever node clear-to-send shows.
// - timestamp request triggers a timestamp packet.
// - 8 data bits, no parity, 9600 baud.
// - handshake and timestamp lines are active low.
// - timestamp request detected on falling edge.
module mu_uart_node #(
	parameter [31:0] RTS_TIMEOUT_CYC = `MU_RTS_TIMEOUT_CYC,
	parameter [31:0] RTS_RETRY_CYC = `MU_RTS_RETRY_CYC,
	parameter [15:0] BIT_CYC = `MU_BIT_CYCLES
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire rxd_i,
	output reg txd_o,
	input wire host_clear_to_send_n_i,
	output reg node_request_to_send_n_o,
	output reg node_clear_to_send_n_o,
	input wire time_request_n_i,
	input wire net_joined_i,
	input wire buf_room_i,
	input wire pkt_valid_i,
	input wire [7:0] pkt_byte_i,
	input wire pkt_last_i,
	output reg pkt_ready_o,
	output reg rx_valid_o,
	output reg [7:0] rx_data_o,
	output reg time_pkt_sent_o
);
	localparam [15:0] HALF_CYC = BIT_CYC / 16'd2;
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_RTS = 6'h02;
	localparam [5:0] S_RETRY = 6'h04;
	localparam [5:0] S_LOAD = 6'h08;
	localparam [5:0] S_SEND = 6'h10;
	localparam [5:0] S_DONE = 6'h20;

	// -------------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------------
	reg [1:0] rx_sync_ff;
	reg [1:0] cts_sync_ff;
	reg [1:0] time_sync_ff;
	reg time_prev_ff;
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_sync_ff <= 2'b11;
			cts_sync_ff <= 2'b11;
			time_sync_ff <= 2'b11;
			time_prev_ff <= 1'b1;
		end else begin
			rx_sync_ff <= {rx_sync_ff[0], rxd_i};
			cts_sync_ff <= {cts_sync_ff[0], host_clear_to_send_n_i};
			time_sync_ff <= {time_sync_ff[0], time_request_n_i};
			time_prev_ff <= time_sync_ff[1];
		end
	end
	wire rxd_s = rx_sync_ff[1];
	wire host_cts_low = ~cts_sync_ff[1];
	wire time_fall = time_prev_ff & ~time_sync_ff[1];

	// -------------------------------------------------------------------
	// receiver
	// -------------------------------------------------------------------
	reg rx_busy_ff;
	reg [15:0] rx_cnt_ff;
	reg [3:0] rx_bit_ff;
	reg [7:0] rx_shf_ff;
	// sample receive line; taken regardless of node clear-to-send
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_busy_ff <= 1'b0;
			rx_cnt_ff <= 16'h0000;
			rx_bit_ff <= 4'h0;
			rx_shf_ff <= 8'h00;
			rx_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
		end else begin
			rx_valid_o <= 1'b0;
			if (!rx_busy_ff) begin
				if (!rxd_s) begin
					rx_busy_ff <= 1'b1;
					rx_cnt_ff <= HALF_CYC;
					rx_bit_ff <= 4'h0;
				end
			end else if (rx_cnt_ff == BIT_CYC - 16'h0001) begin
				rx_cnt_ff <= 16'h0000;
				rx_bit_ff <= rx_bit_ff + 4'h1;
				if (rx_bit_ff == 4'h0) begin
					if (rxd_s)
						rx_busy_ff <= 1'b0; // false start
				end else if (rx_bit_ff == 4'h9) begin
					rx_busy_ff <= 1'b0;
					// stop bit checked, 8 data bits
					if (rxd_s) begin
						rx_valid_o <= 1'b1;
						rx_data_o <= rx_shf_ff;
					end
				end else begin
					rx_shf_ff <= {rxd_s, rx_shf_ff[7:1]};
				end
			end else begin
				rx_cnt_ff <= rx_cnt_ff + 16'h0001;
			end
		end
	end

	// -------------------------------------------------------------------
	// node clear-to-send
	// -------------------------------------------------------------------
	always @(posedge core_clk_i) begin
		if (rst_i)
			node_clear_to_send_n_o <= 1'b1;
		else
			// low only when joined with room; active low
			node_clear_to_send_n_o <= ~(net_joined_i & buf_room_i);
	end

	// -------------------------------------------------------------------
	// transmit handshake state machine
	// -------------------------------------------------------------------
	reg [5:0] st_ff;
	reg [31:0] tmr_ff;
	reg time_pend_ff;
	reg time_act_ff;
	reg tx_start_ff;
	reg [7:0] tx_byte_ff;
	reg last_ff;
	wire tx_busy;
	wire tx_line;
	mu_uart_tx #(
		.BIT_CYC(BIT_CYC)
	) u_tx (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.start_i(tx_start_ff),
		.data_i(tx_byte_ff),
		.busy_o(tx_busy),
		.txd_o(tx_line)
	);
	always @(posedge core_clk_i) begin
		if (rst_i)
			txd_o <= 1'b1;
		else
			txd_o <= tx_line;
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			st_ff <= S_IDLE;
			tmr_ff <= 32'h00000000;
			time_pend_ff <= 1'b0;
			time_act_ff <= 1'b0;
			tx_start_ff <= 1'b0;
			tx_byte_ff <= 8'h00;
			last_ff <= 1'b0;
			node_request_to_send_n_o <= 1'b1;
			pkt_ready_o <= 1'b0;
			time_pkt_sent_o <= 1'b0;
		end else begin
			tx_start_ff <= 1'b0;
			pkt_ready_o <= 1'b0;
			time_pkt_sent_o <= 1'b0;
			// a request sets pending; set wins over clear
			if (time_fall)
				time_pend_ff <= 1'b1;
			case (st_ff)
			S_IDLE: begin
				if (time_pend_ff || pkt_valid_i) begin
					time_act_ff <= time_pend_ff;
					if (time_pend_ff && !time_fall)
						time_pend_ff <= 1'b0;
					node_request_to_send_n_o <= 1'b0;
					tmr_ff <= 32'h00000000;
					st_ff <= S_RTS;
				end
			end
			S_RTS: begin
				// start only once host clear-to-send seen low
				if (host_cts_low) begin
					st_ff <= S_LOAD;
				// timeout releases request, go to retry wait
				end else if (tmr_ff == RTS_TIMEOUT_CYC - 32'h1) begin
					node_request_to_send_n_o <= 1'b1;
					tmr_ff <= 32'h00000000;
					st_ff <= S_RETRY;
				end else begin
					tmr_ff <= tmr_ff + 32'h1;
				end
			end
			S_RETRY: begin
				if (tmr_ff == RTS_RETRY_CYC - 32'h1) begin
					node_request_to_send_n_o <= 1'b0;
					tmr_ff <= 32'h00000000;
					st_ff <= S_RTS;
				end else begin
					tmr_ff <= tmr_ff + 32'h1;
				end
			end
			S_LOAD: begin
				if (time_act_ff) begin
					tx_byte_ff <= `MU_TIME_PKT_BYTE;
					last_ff <= 1'b1;
					tx_start_ff <= 1'b1;
					st_ff <= S_SEND;
				end else if (pkt_valid_i) begin
					tx_byte_ff <= pkt_byte_i;
					last_ff <= pkt_last_i;
					pkt_ready_o <= 1'b1;
					tx_start_ff <= 1'b1;
					st_ff <= S_SEND;
				end
			end
			S_SEND: begin
				if (!tx_start_ff && !tx_busy)
					st_ff <= last_ff ? S_DONE : S_LOAD;
			end
			S_DONE: begin
				// request released after the whole packet, never between its bytes
				node_request_to_send_n_o <= 1'b1;
				time_pkt_sent_o <= time_act_ff;
				time_act_ff <= 1'b0;
				st_ff <= S_IDLE;
			end
			default: begin
				st_ff <= S_IDLE;
				node_request_to_send_n_o <= 1'b1;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: mu_uart_node_chk.sv
// checker for the node serial port handshake lines
`timescale 1ns/1ps
`default_nettype none
module mu_uart_node_chk #(
	parameter [31:0] RTS_TIMEOUT_CYC = 32'd50,
	parameter [31:0] RTS_RETRY_CYC = 32'd20
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic rxd_i,
	input wire logic txd_o,
	input wire logic host_clear_to_send_n_i,
	input wire logic node_request_to_send_n_o,
	input wire logic node_clear_to_send_n_o,
	input wire logic time_request_n_i,
	input wire logic net_joined_i,
	input wire logic buf_room_i,
	input wire logic pkt_valid_i,
	input wire logic [7:0] pkt_byte_i,
	input wire logic pkt_last_i,
	input wire logic pkt_ready_o,
	input wire logic rx_valid_o,
	input wire logic [7:0] rx_data_o,
	input wire logic time_pkt_sent_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic [31:0] wait_ff;
	// ---------------------------------------------
	// request waiting for a grant
	// ---------------------------------------------
	// cycles spent requesting with no grant from the host
	always @(posedge core_clk_i) begin
		if (rst_i || node_request_to_send_n_o || !host_clear_to_send_n_i)
			wait_ff <= 32'h0;
		else
			wait_ff <= wait_ff + 32'h1;
	end
	sequence s_req_low;
		(!node_request_to_send_n_o)[*8];
	endsequence
	sequence s_req_high;
		node_request_to_send_n_o[*8];
	endsequence
	AST_CTS_JOIN: assert property (!net_joined_i |=> node_clear_to_send_n_o)
		else $error("cts low off network");
	AST_CTS_ROOM: assert property (!buf_room_i |=> node_clear_to_send_n_o)
		else $error("cts low without room");
	AST_CTS_ON: assert property (net_joined_i && buf_room_i |=> !node_clear_to_send_n_o)
		else $error("cts high while ready");
	AST_TX_IDLE: assert property (node_request_to_send_n_o |-> txd_o)
		else $error("data sent without request");
	AST_TX_START: assert property ($fell(txd_o) |->
		!node_request_to_send_n_o && !$past(host_clear_to_send_n_i, 3))
		else $error("frame started without grant");
	AST_RTS_HOLD: assert property ($fell(node_request_to_send_n_o) |-> s_req_low)
		else $error("request dropped early");
	AST_RTS_RETRY: assert property ($rose(node_request_to_send_n_o) &&
		host_clear_to_send_n_i |-> s_req_high)
		else $error("retry gap too short");
	AST_RTS_TIMEOUT: assert property (wait_ff <= RTS_TIMEOUT_CYC + 32'd3)
		else $error("request held past timeout");
endmodule
bind mu_uart_node mu_uart_node_chk #(
	.RTS_TIMEOUT_CYC(RTS_TIMEOUT_CYC),
	.RTS_RETRY_CYC(RTS_RETRY_CYC)
) u_chk (
	.core_clk_i(core_clk_i),
	.rst_i(rst_i),
	.rxd_i(rxd_i),
	.txd_o(txd_o),
	.host_clear_to_send_n_i(host_clear_to_send_n_i),
	.node_request_to_send_n_o(node_request_to_send_n_o),
	.node_clear_to_send_n_o(node_clear_to_send_n_o),
	.time_request_n_i(time_request_n_i),
	.net_joined_i(net_joined_i),
	.buf_room_i(buf_room_i),
	.pkt_valid_i(pkt_valid_i),
	.pkt_byte_i(pkt_byte_i),
	.pkt_last_i(pkt_last_i),
	.pkt_ready_o(pkt_ready_o),
	.rx_valid_o(rx_valid_o),
	.rx_data_o(rx_data_o),
	.time_pkt_sent_o(time_pkt_sent_o)
);
`default_nettype wire

// file: mu_host_model.sv
// host side model: grants clear-to-send while ready and asked
`timescale 1ns/1ps
`default_nettype none
module mu_host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ready_i,
	input wire logic req_n_i,
	output logic cts_n_o
);
	always @(posedge clk_i) begin
		cts_n_o <= rst_i | ~(ready_i & ~req_n_i);
	end
endmodule
`default_nettype wire

// file: mu_uart_node_tb.sv
// testbench for the node serial port
`timescale 1ns/1ps
`default_nettype none
`include "mu_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t mismatch", $time); end end
module mu_uart_node_tb;
	localparam logic [7:0] STAMP = `MU_TIME_PKT_BYTE;
	// short bit time keeps whole frames inside the run budget
	localparam logic [15:0] BIT_LEN = 16'd40;
	logic clk = 0, rst = 1, ready = 0, tr_n = 1, joined = 0, room = 0;
	logic rxd = 1, pv = 0, pl = 0;
	logic [7:0] pb = 8'h00;
	logic txd, rts_n, cts_n, ncts_n, prdy, rxv, tsent;
	logic [7:0] rxb;
	int err_total = 0, checked = 0, n;
	// clock 200 MHz
	always #2.5 clk = ~clk;
	mu_uart_node #(.RTS_TIMEOUT_CYC(32'd50), .RTS_RETRY_CYC(32'd20),
		.BIT_CYC(BIT_LEN)) dut (
		.core_clk_i(clk), .rst_i(rst), .rxd_i(rxd), .txd_o(txd),
		.host_clear_to_send_n_i(cts_n), .node_request_to_send_n_o(rts_n),
		.node_clear_to_send_n_o(ncts_n), .time_request_n_i(tr_n),
		.net_joined_i(joined), .buf_room_i(room), .pkt_valid_i(pv),
		.pkt_byte_i(pb), .pkt_last_i(pl), .pkt_ready_o(prdy),
		.rx_valid_o(rxv), .rx_data_o(rxb), .time_pkt_sent_o(tsent));
	mu_host_model host (.clk_i(clk), .rst_i(rst), .ready_i(ready),
		.req_n_i(rts_n), .cts_n_o(cts_n));
	// wait until the request line shows v, n counts edges
	task automatic wait_rts(input logic v, input int lim);
		n = 0;
		while (rts_n !== v && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic t_cts;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			joined <= i[1];
			room <= i[0];
			repeat (2) @(posedge clk);
			#1;
			`CHK(ncts_n, !(i == 3))
		end
		$display("test cts done");
	endtask
	task automatic t_retry;
		@(posedge clk);
		tr_n <= 1'b0;
		wait_rts(1'b0, 20);
		`CHK(rts_n, 1'b0)
		wait_rts(1'b1, 80);
		`CHK(n >= 48 && n <= 52, 1'b1)
		wait_rts(1'b0, 40);
		`CHK(n >= 18 && n <= 22, 1'b1)
		$display("test retry done");
	endtask
	// whole frame on the transmit line, request held low throughout
	task automatic chk_frame(input logic [7:0] exp);
		n = 0;
		while (txd !== 1'b0 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		repeat (BIT_LEN / 2) @(posedge clk);
		#1;
		`CHK(txd, 1'b0)
		for (int b = 0; b < 8; b++) begin
			repeat (BIT_LEN) @(posedge clk);
			#1;
			`CHK({txd, rts_n}, {exp[b], 1'b0})
		end
		repeat (BIT_LEN) @(posedge clk);
		#1;
		`CHK({txd, rts_n}, 2'b10)
	endtask
	// wait for the byte-taken pulse, n counts edges
	task automatic wait_rdy;
		n = 0;
		while (prdy !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	// drive one frame on the receive line and look for the byte
	task automatic send_rx(input logic [7:0] v);
		logic [8:0] f;
		f = {v, 1'b0};
		@(posedge clk);
		for (int b = 0; b < 9; b++) begin
			rxd <= f[b];
			repeat (BIT_LEN) @(posedge clk);
		end
		rxd <= 1'b1;
		n = 0;
		while (rxv !== 1'b1 && n < 2 * BIT_LEN) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK({rxv, rxb}, {1'b1, v})
		@(posedge clk);
		#1;
		`CHK(rxv, 1'b0)
		repeat (BIT_LEN) @(posedge clk);
	endtask
	task automatic t_rx;
		@(posedge clk);
		joined <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(ncts_n, 1'b1)
		send_rx(8'h96);
		@(posedge clk);
		joined <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK(ncts_n, 1'b0)
		send_rx(8'h5a);
		$display("test receive done");
	endtask
	task automatic t_stamp;
		@(posedge clk);
		ready <= 1'b1;
		tr_n <= 1'b1;
		chk_frame(STAMP);
		repeat (BIT_LEN / 2) @(posedge clk);
		#1;
		`CHK({tsent, rts_n}, 2'b11)
		@(posedge clk);
		#1;
		`CHK(tsent, 1'b0)
		$display("test stamp done");
	endtask
	task automatic t_pkt;
		@(posedge clk);
		pv <= 1'b1;
		pb <= 8'ha5;
		pl <= 1'b0;
		wait_rdy;
		`CHK({prdy, rts_n}, 2'b10)
		@(posedge clk);
		pb <= 8'h3c;
		pl <= 1'b1;
		chk_frame(8'ha5);
		wait_rdy;
		`CHK({prdy, rts_n}, 2'b10)
		@(posedge clk);
		pv <= 1'b0;
		chk_frame(8'h3c);
		repeat (BIT_LEN / 2) @(posedge clk);
		#1;
		`CHK({tsent, rts_n}, 2'b01)
		$display("test packet done");
	endtask
	task automatic close_out;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(ncts_n, 1'b1)
		t_cts;
		t_rx;
		t_retry;
		t_stamp;
		t_pkt;
		close_out;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out;
	end
endmodule
`default_nettype wire
